// ### rtl/calibration_word_top.sv
// Calendar clock with alarm, calibration and secure clock support
`timescale 1ns/1ns
module calibration_word_top (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic timebase_32k_in,
  input wire logic backup_por_n_in,
  input wire logic coin_cell_only_in,
  input wire logic system_off_in,
  input wire logic app_on_in,
  input wire logic power_key_pin_in,
  output logic processor_ref_clock_out,
  output logic peripheral_clock_out,
  output logic secure_rtc_supply_en_out,
  output logic app_power_on_req_out,
  output logic key_press_out,
  output logic irq_out
);
  import calibration_word_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic bk_rst;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic clock_calendar_disable_q;
  logic secure_clock_keepalive_q;
  calibration_word_mode_e calibration_mode_q;
  logic [CAL_W-1:0] calibration_word_q;
  logic [SEC_W-1:0] seconds_of_day_counter_q;
  logic [DAY_W-1:0] day_counter_q;
  logic [SEC_W-1:0] alarm_seconds_q;
  logic [DAY_W-1:0] alarm_day_q;
  logic tick_irq_flag_q;
  logic alarm_irq_flag_q;
  logic clock_lost_irq_flag_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] flags;
  logic [IRQ_W-1:0] irq_clr;
  logic tick;
  logic cal_active;
  logic match;
  logic match_q;
  logic alarm_hit;
  logic ref_clk_q;
  logic periph_clk_q;
  logic supply_q;
  logic pwr_req_q;
  logic key_q;
  logic irq_q;
  logic wr_ctrl;
  logic wr_sec;
  logic wr_day;
  logic wr_asec;
  logic wr_aday;
  logic wr_stat;
  logic wr_mask;

  // Backup reset loads every coin-cell-backed register with its reset value; alarm registers go to all ones, lost flag sets
  assign bk_rst = rst_in || !backup_por_n_in;

  // ----------------------------------------------------------------
  // Bus slave and write decode
  // ----------------------------------------------------------------
  calibration_word_ahb u_ahb (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hready_in(hready_in),
    .hwdata_in(hwdata_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  assign wr_ctrl = wr_en && wr_addr == OFF_CTRL;
  assign wr_sec = wr_en && wr_addr == OFF_SECONDS;
  assign wr_day = wr_en && wr_addr == OFF_DAY;
  assign wr_asec = wr_en && wr_addr == OFF_ALARM_SECONDS;
  assign wr_aday = wr_en && wr_addr == OFF_ALARM_DAY;
  assign wr_stat = wr_en && wr_addr == OFF_IRQ_STATUS;
  assign wr_mask = wr_en && wr_addr == OFF_IRQ_MASK;
  assign irq_clr = wr_stat ? wr_data[IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) begin
      clock_calendar_disable_q <= 1'b0;
      secure_clock_keepalive_q <= 1'b0;
      calibration_mode_q <= CALIBRATION_WORD_MODE_OFF;
      calibration_word_q <= CAL_RST;
    end else if (wr_ctrl) begin
      clock_calendar_disable_q <= wr_data[CTRL_DIS_BIT];
      secure_clock_keepalive_q <= wr_data[CTRL_KEEP_BIT];
      calibration_mode_q <= calibration_word_mode_e'(wr_data[CTRL_MODE_LSB +: 2]);
      calibration_word_q <= wr_data[CTRL_CAL_LSB +: CAL_W];
    end
  end

  // Mode 01 drops calibration on coin cell, reserved code acts as off
  assign cal_active = calibration_word_cal_on(calibration_mode_q,
                                    coin_cell_only_in);

  // ----------------------------------------------------------------
  // One-second divider
  // ----------------------------------------------------------------
  calibration_word_div #(
    .CNT_W(CNT_W),
    .CAL_W(CAL_W)
  ) u_div (
    .ref_clk_in(ref_clk_in),
    .rst_in(bk_rst),
    .timebase_in(timebase_32k_in),
    .run_in(!clock_calendar_disable_q),
    .cal_en_in(cal_active),
    .cal_word_in(calibration_word_q),
    .tick_out(tick),
    .count_out()
  );

  // ----------------------------------------------------------------
  // Time and day counters
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) begin
      seconds_of_day_counter_q <= SEC_ZERO;
    end else if (wr_sec) begin
      seconds_of_day_counter_q <= wr_data[SEC_W-1:0];
    end else if (tick) begin
      seconds_of_day_counter_q <= (seconds_of_day_counter_q >= SEC_MAX) ?
        SEC_ZERO : SEC_W'(seconds_of_day_counter_q + 1'b1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) begin
      day_counter_q <= '0;
    end else if (wr_day) begin
      day_counter_q <= wr_data[DAY_W-1:0];
    end else if (tick && seconds_of_day_counter_q >= SEC_MAX && !wr_sec) begin
      day_counter_q <= DAY_W'(day_counter_q + DAY_ONE);
    end
  end

  // ----------------------------------------------------------------
  // Alarm registers and match
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) begin
      alarm_seconds_q <= ALARM_SEC_RST;
      alarm_day_q <= ALARM_DAY_RST;
    end else begin
      if (wr_asec) alarm_seconds_q <= wr_data[SEC_W-1:0];
      if (wr_aday) alarm_day_q <= wr_data[DAY_W-1:0];
    end
  end

  assign match = seconds_of_day_counter_q == alarm_seconds_q &&
                 day_counter_q == alarm_day_q;

  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) match_q <= 1'b0;
    else match_q <= match;
  end

  // One event per arrival at the alarm time
  assign alarm_hit = match && !match_q;

  // ----------------------------------------------------------------
  // Interrupt flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) tick_irq_flag_q <= 1'b0;
    else tick_irq_flag_q <= tick || (tick_irq_flag_q && !irq_clr[IRQ_TICK]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) alarm_irq_flag_q <= 1'b0;
    else alarm_irq_flag_q <= alarm_hit ||
      (alarm_irq_flag_q && !irq_clr[IRQ_ALARM]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) clock_lost_irq_flag_q <= 1'b1;
    else if (irq_clr[IRQ_LOST]) clock_lost_irq_flag_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (bk_rst) irq_mask_q <= MASK_RST;
    else if (wr_mask) irq_mask_q <= wr_data[IRQ_W-1:0];
  end

  assign flags = {clock_lost_irq_flag_q, alarm_irq_flag_q, tick_irq_flag_q};

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) irq_q <= 1'b0;
    else irq_q <= |(flags & ~irq_mask_q);
  end

  // Unmasked alarm with the application off asks for power on
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) pwr_req_q <= 1'b0;
    else pwr_req_q <= alarm_hit && !irq_mask_q[IRQ_ALARM] && !app_on_in;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      OFF_CTRL: begin
        rd_data[CTRL_DIS_BIT] = clock_calendar_disable_q;
        rd_data[CTRL_KEEP_BIT] = secure_clock_keepalive_q;
        rd_data[CTRL_MODE_LSB +: 2] = calibration_mode_q;
        rd_data[CTRL_CAL_LSB +: CAL_W] = calibration_word_q;
      end
      OFF_SECONDS: rd_data[SEC_W-1:0] = seconds_of_day_counter_q;
      OFF_DAY: rd_data[DAY_W-1:0] = day_counter_q;
      OFF_ALARM_SECONDS: rd_data[SEC_W-1:0] = alarm_seconds_q;
      OFF_ALARM_DAY: rd_data[DAY_W-1:0] = alarm_day_q;
      OFF_IRQ_STATUS: rd_data[IRQ_W-1:0] = flags;
      OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
      OFF_STATUS: begin
        rd_data[STAT_CAL_BIT] = cal_active;
        rd_data[STAT_COIN_BIT] = coin_cell_only_in;
      end
      default: rd_data = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock outputs, supply and power key
  // ----------------------------------------------------------------
  // Both outputs follow the raw time base, untouched by calibration
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) ref_clk_q <= 1'b0;
    else ref_clk_q <= timebase_32k_in &&
      (secure_clock_keepalive_q || !system_off_in);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) periph_clk_q <= 1'b0;
    else periph_clk_q <= timebase_32k_in && !system_off_in;
  end

  // No register bit reaches this supply enable
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) supply_q <= 1'b0;
    else supply_q <= 1'b1;
  end

  // A processor pull on the pin looks exactly like the key
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) key_q <= 1'b0;
    else key_q <= !power_key_pin_in;
  end

  assign processor_ref_clock_out = ref_clk_q;
  assign peripheral_clock_out = periph_clk_q;
  assign secure_rtc_supply_en_out = supply_q;
  assign app_power_on_req_out = pwr_req_q;
  assign key_press_out = key_q;
  assign irq_out = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_keepalive_ref: assert property (
    secure_clock_keepalive_q && backup_por_n_in && !wr_ctrl
    |=> processor_ref_clock_out == $past(timebase_32k_in))
    else $error("reference clock dropped with keepalive set");
  a_off_ref_low: assert property (
    !secure_clock_keepalive_q && system_off_in |=> !processor_ref_clock_out)
    else $error("reference clock driven in off state");
  a_supply_stays: assert property (
    $past(secure_rtc_supply_en_out) |-> secure_rtc_supply_en_out)
    else $error("secure supply turned off");
  a_sec_range: assert property (
    seconds_of_day_counter_q <= SEC_MAX || $past(wr_sec))
    else $error("seconds counter beyond day end");
  a_sec_wrap: assert property (
    tick && seconds_of_day_counter_q == SEC_MAX && !wr_sec && !wr_day &&
    !bk_rst
    |=> seconds_of_day_counter_q == SEC_ZERO &&
        day_counter_q == DAY_W'($past(day_counter_q) + DAY_ONE))
    else $error("day roll over wrong");
  a_tick_flag_set: assert property (
    tick && !bk_rst |=> tick_irq_flag_q ##1 irq_out || irq_mask_q[IRQ_TICK])
    else $error("tick flag not set");
  a_alarm_flag_set: assert property (
    alarm_hit && !bk_rst |=> alarm_irq_flag_q)
    else $error("alarm flag not set on match");
  a_alarm_rst_ones: assert property (
    !backup_por_n_in
    |=> alarm_seconds_q == ALARM_SEC_RST && alarm_day_q == ALARM_DAY_RST)
    else $error("alarm registers not all ones after backup reset");
  a_alarm_mask_pwr: assert property (
    app_power_on_req_out |-> $past(!irq_mask_q[IRQ_ALARM]) && $past(alarm_hit))
    else $error("power on request while alarm masked");
  a_alarm_power_on: assert property (
    alarm_hit && !irq_mask_q[IRQ_ALARM] && !app_on_in && !bk_rst
    |=> app_power_on_req_out ##1 !app_power_on_req_out)
    else $error("unmasked alarm did not power on");
  a_lost_set: assert property (
    !backup_por_n_in
    |=> clock_lost_irq_flag_q && seconds_of_day_counter_q == SEC_ZERO &&
        day_counter_q == '0)
    else $error("backup reset did not clear clock");
  a_cal_coin_off: assert property (
    calibration_mode_q == CALIBRATION_WORD_MODE_MAIN && coin_cell_only_in |-> !cal_active)
    else $error("calibration active on coin cell in mode 01");
  a_key_press: assert property (
    !power_key_pin_in |=> key_press_out)
    else $error("power key pull not seen as press");

  c_day_wrap: cover property (tick && seconds_of_day_counter_q == SEC_MAX);
  c_alarm_wake: cover property (alarm_hit && !irq_mask_q[IRQ_ALARM]);
  c_cal_neg: cover property (cal_active && calibration_word_q[CAL_W-1] && tick);
  c_lost_clear: cover property (clock_lost_irq_flag_q ##1 !clock_lost_irq_flag_q);

endmodule : calibration_word_top

// ### rtl/calibration_word_pkg.sv
// Shared constants and types of the calendar clock with alarm and calibration
package calibration_word_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEC_W = 17;
  localparam int DAY_W = 15;
  localparam int CAL_W = 5;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [SEC_W-1:0] SEC_MAX = 17'h1517F;
  localparam logic [SEC_W-1:0] SEC_ZERO = 17'h00000;
  localparam logic [DAY_W-1:0] DAY_ONE = 15'h0001;
  localparam logic [CNT_W-1:0] TICK_NOMINAL = 16'h8000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SECONDS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DAY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ALARM_SECONDS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ALARM_DAY = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DIS_BIT = 0;
  localparam int CTRL_KEEP_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_CAL_LSB = 4;
  localparam int IRQ_TICK = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_LOST = 2;
  localparam int STAT_CAL_BIT = 0;
  localparam int STAT_COIN_BIT = 1;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h3;
  localparam logic [SEC_W-1:0] ALARM_SEC_RST = 17'h1FFFF;
  localparam logic [DAY_W-1:0] ALARM_DAY_RST = 15'h7FFF;
  localparam logic [CAL_W-1:0] CAL_RST = 5'h00;

  // ----------------------------------------------------------------
  // Bus codes
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    CALIBRATION_WORD_MODE_OFF = 2'b00,
    CALIBRATION_WORD_MODE_MAIN = 2'b01,
    CALIBRATION_WORD_MODE_RSVD = 2'b10,
    CALIBRATION_WORD_MODE_ALL = 2'b11
  } calibration_word_mode_e;

  // Calibration on or off for a mode and supply state
  function automatic logic calibration_word_cal_on(input calibration_word_mode_e mode,
                                         input logic coin_only);
    logic on;
    on = 1'b0;
    unique case (mode)
      CALIBRATION_WORD_MODE_OFF: on = 1'b0;
      CALIBRATION_WORD_MODE_MAIN: on = ~coin_only;
      CALIBRATION_WORD_MODE_RSVD: on = 1'b0;
      CALIBRATION_WORD_MODE_ALL: on = 1'b1;
    endcase
    return on;
  endfunction : calibration_word_cal_on

endpackage : calibration_word_pkg

// ### rtl/calibration_word_div.sv
// One-second tick divider with signed terminal count correction
`timescale 1ns/1ns
module calibration_word_div #(
  parameter int CNT_W = 16,
  parameter int CAL_W = 5
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic timebase_in,
  input wire logic run_in,
  input wire logic cal_en_in,
  input wire logic [CAL_W-1:0] cal_word_in,
  output logic tick_out,
  output logic [CNT_W-1:0] count_out
);
  import calibration_word_pkg::*;

  logic tb_q;
  logic tick_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] term;
  logic edge_seen;

  assign edge_seen = timebase_in & ~tb_q;
  // Positive code shortens the second, giving more ticks per real second
  assign term = cal_en_in ?
    CNT_W'(TICK_NOMINAL - {{(CNT_W-CAL_W){cal_word_in[CAL_W-1]}},
                           cal_word_in}) : TICK_NOMINAL;

  // Tracks the input through reset so a high level is no false edge
  always_ff @(posedge ref_clk_in) begin
    tb_q <= timebase_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !run_in) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    // A second shortened mid-count ends at the next time base edge, no counter wrap
    end else if (edge_seen && cnt_q >= CNT_W'(term - CNT_ONE)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= edge_seen ? CNT_W'(cnt_q + CNT_ONE) : cnt_q;
      tick_q <= 1'b0;
    end
  end

  assign tick_out = tick_q;
  assign count_out = cnt_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_div_terminal: assert property (
    run_in && edge_seen && cnt_q == CNT_W'(term - CNT_ONE)
    |=> tick_out && count_out == '0)
    else $error("divider missed terminal count");
  a_div_cal_term: assert property (
    cal_en_in && run_in |-> cnt_q < term)
    else $error("divider count beyond corrected terminal");
  a_div_stop: assert property (
    !run_in |=> !tick_out && count_out == '0)
    else $error("divider ran while stopped");

endmodule : calibration_word_div

// ### rtl/calibration_word_ahb.sv
// AHB-Lite slave front end, zero wait states, always OKAY
`timescale 1ns/1ns
module calibration_word_ahb (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [calibration_word_pkg::ADDR_W-1:0] rd_addr_out,
  input wire logic [calibration_word_pkg::DATA_W-1:0] rd_data_in,
  output logic wr_en_out,
  output logic [calibration_word_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [calibration_word_pkg::DATA_W-1:0] wr_data_out
);
  import calibration_word_pkg::*;

  logic take;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] hrdata_q;

  assign take = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) wr_pend_q <= 1'b0;
    else wr_pend_q <= take && hwrite_in && hsize_in == HSIZE_WORD;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) wr_addr_q <= '0;
    else if (take) wr_addr_q <= haddr_in[ADDR_W-1:0];
  end

  // Read data sampled at the address phase, shown in the data phase
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) hrdata_q <= '0;
    else if (take && !hwrite_in) hrdata_q <= rd_data_in;
  end

  assign rd_addr_out = haddr_in[ADDR_W-1:0];
  assign wr_en_out = wr_pend_q;
  assign wr_addr_out = wr_addr_q;
  assign wr_data_out = hwdata_in;
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = HRESP_OKAY;

endmodule : calibration_word_ahb

// ### dv/calibration_word_cpu_model.sv
// Processor side model driving the power key pin high and low from a register
`timescale 1ns/1ns
module calibration_word_cpu_model (
  input wire logic ref_clk_in,
  input wire logic wake_in,
  output logic power_key_pin_out = 1'b1
);
  // Pulled up when released, pulled low while waking the system
  always @(posedge ref_clk_in) begin
    power_key_pin_out <= ~wake_in;
  end
endmodule : calibration_word_cpu_model

// ### dv/tb.sv
// Self-checking bench of the calendar clock
`timescale 1ns/1ns
module tb;
  import calibration_word_pkg::*;
  logic clk = 0, rst = 1, sel = 0, wr = 0, tbase = 0, run = 0, rd_ph = 0;
  logic bpor_n = 1, coin = 0, off = 0, wake = 0, app = 0;
  logic [1:0] trans = 0;
  logic [2:0] size = 3'h2;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic rdy, resp, pref, pper, sup, pon, key, irq, pin;
  logic [31:0] exp_q[$];
  logic [14:0] d;
  int mismatches = 0, compares = 0, cyc = 0, i;
  calibration_word_top calibration_word_top_inst (.ref_clk_in(clk), .rst_in(rst), .hsel_in(sel),
    .haddr_in(addr), .htrans_in(trans), .hwrite_in(wr), .hsize_in(size),
    .hready_in(rdy), .hwdata_in(wdata), .hrdata_out(rdata),
    .hreadyout_out(rdy), .hresp_out(resp), .timebase_32k_in(tbase),
    .backup_por_n_in(bpor_n), .coin_cell_only_in(coin),
    .system_off_in(off), .app_on_in(app), .power_key_pin_in(pin),
    .processor_ref_clock_out(pref), .peripheral_clock_out(pper),
    .secure_rtc_supply_en_out(sup), .app_power_on_req_out(pon),
    .key_press_out(key), .irq_out(irq));
  calibration_word_cpu_model calibration_word_cpu_model_inst (.ref_clk_in(clk), .wake_in(wake),
    .power_key_pin_out(pin));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (run) tbase <= ~tbase;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      end_sim();
    end
  end
  task check(input string n, input logic [31:0] seen, input logic [31:0] e);
    compares++;
    if (seen !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
    end
  endtask : check
  // Read data and response compared at the edge closing the data phase
  always @(posedge clk) begin
    if (rd_ph && rdy === 1'b1) begin
      check("hrdata", rdata, exp_q.pop_front());
      check("hresp", resp, 0);
    end
  end
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v,
           input logic [31:0] e);
    @(posedge clk);
    sel <= 1;
    trans <= 2'h2;
    addr <= {24'h0, a};
    wr <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    trans <= 2'h0;
    wdata <= v;
    if (!w) exp_q.push_back(e);
    rd_ph <= !w;
    do @(posedge clk); while (rdy !== 1'b1);
    rd_ph <= 0;
  endtask : bus
  task end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(34));
    d = 15'($urandom % 32767);
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (2) @(negedge clk);
    check("supply", sup, 1);
    bus(0, OFF_CTRL, 0, 0);
    bus(0, OFF_IRQ_MASK, 0, 3);
    bus(0, 8'h20, 0, 0);
    coin <= 1;
    for (i = 0; i < 4; i++) begin
      bus(1, OFF_CTRL, 32'hF0 | (i << 2), 0);
      bus(0, OFF_STATUS, 0, {30'h0, 1'b1, i == 3});
    end
    coin <= 0;
    bus(1, OFF_CTRL, 32'hF6, 0);
    bus(0, OFF_STATUS, 0, 1);
    bus(1, OFF_CTRL, 32'hFE, 0);
    off <= 1;
    bus(1, OFF_SECONDS, SEC_MAX, 0);
    bus(1, OFF_DAY, d, 0);
    bus(1, OFF_ALARM_SECONDS, 0, 0);
    bus(1, OFF_ALARM_DAY, {17'h0, d + 15'h1}, 0);
    bus(1, OFF_IRQ_MASK, 1, 0);
    bus(1, OFF_IRQ_STATUS, 7, 0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq", irq, 0);
    run <= 1;
    repeat (3) @(negedge clk);
    check("refclk", pref, !tbase);
    repeat (65480) @(posedge clk);
    bus(0, OFF_SECONDS, 0, SEC_MAX);
    for (i = 0; i < 40 && pon !== 1'b1; i++) @(negedge clk);
    check("poweron", pon, 1);
    run <= 0;
    bus(0, OFF_SECONDS, 0, 0);
    bus(0, OFF_DAY, 0, {17'h0, d + 15'h1});
    bus(0, OFF_IRQ_STATUS, 0, 3);
    check("irq", irq, 1);
    bus(1, OFF_CTRL, 32'hFC, 0);
    run <= 1;
    repeat (3) @(negedge clk);
    check("refclk", pref, 0);
    @(posedge clk);
    off <= 0;
    repeat (2) @(negedge clk);
    check("periph", pper, !tbase);
    run <= 0;
    wake <= 1;
    repeat (3) @(negedge clk);
    check("key", key, 1);
    wake <= 0;
    @(posedge clk);
    bpor_n <= 0;
    @(posedge clk);
    bpor_n <= 1;
    bus(0, OFF_SECONDS, 0, 0);
    bus(0, OFF_ALARM_SECONDS, 0, ALARM_SEC_RST);
    bus(0, OFF_ALARM_DAY, 0, ALARM_DAY_RST);
    bus(0, OFF_IRQ_MASK, 0, 3);
    bus(0, OFF_IRQ_STATUS, 0, 4);
    app <= 1;
    bus(1, OFF_IRQ_MASK, 0, 0);
    bus(1, OFF_ALARM_SECONDS, 0, 0);
    bus(1, OFF_ALARM_DAY, 0, 0);
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      check("poweron", pon, 0);
    end
    bus(0, OFF_IRQ_STATUS, 0, 6);
    check("irq", irq, 1);
    check("supply", sup, 1);
    end_sim();
  end
endmodule : tb
